// File: pic_core.sv
// Overview of operation
// (R1) all state changes on the rising clock edge only
// (R2) cascade service in forces request high, blocks top clears
// (R3) cascade pending in forces request high, clears vector enable
// (R4) cascade service out: any in-service bit or cascade service in
// (R5) cascade pending out: any unmasked pending or cascade pending in
// (R6) opcode ignored while instruction valid is high
// (R7) bus opcodes 4 to 15 ignored while chip select is high
// (R8) pulse mode: latch catches pulse, pending sets, then clears latch
// (R9) level mode: pending follows the request line while held low
// (R10) level-mode source holds its line low until acknowledged
// (R11) mask pending, encode highest-numbered unmasked request
// (R12) mask suppresses a request but leaves pending bit intact
// (R13) vector register reloads every edge with the top code
// (R14) request low only above in-service level; high during ack
// (R15) in-service bit blocks equal and lower priority requests
// (R16) in-service bit stays set until an instruction clears it
// (R17) vector enable follows unmasked pending; output active low
// (R18) ack with vector enable: drive vector, clear pending, set service
// (R19) vector pins driven only while ack and vector enable low
// (R20) delayed mode delays cascade service in and in-service top
// (R21) reset clears latches, pending, in-service and mask
// (R22) pending bits settable by instruction as soft requests
// (R23) opcode map: clears, nop, then mask, service, pending groups
// (R24) bit set and bit clear touch only bits with data one
// (R25) clear current pending uses in-service top, delayed if asked
// (R26) service writes beat ack; ack beats pending writes
// (R27) data bus driven only by an enabled selected read
`timescale 1ns/1ns
module pic_core (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // request pins, active low, asynchronous
  input  wire logic [pic_pkg::NREQ-1:0]   requestLinesN,
  // static mode straps
  input  wire logic                       requestCaptureMode,
  input  wire logic                       delayedServiceMode,
  // instruction port from the pipeline register
  input  wire pic_pkg::pic_instr_t        instrIn,
  // data bus, split into its three signals
  input  wire logic [pic_pkg::NREQ-1:0]   dataBusIn,
  output logic      [pic_pkg::NREQ-1:0]   dataBusOut,
  output logic                            dataBusOe,
  // acknowledge from the sequencer
  input  wire logic                       irqAcknowledgeN,
  // open-collector request: oe high pulls the wire low
  output logic                            irqRequestNOut,
  output logic                            irqRequestNOe,
  // vector pins
  output logic      [pic_pkg::CODE_W-1:0] vectorOut,
  output logic                            vectorOe,
  output logic                            vectorValidN,
  // cascade chain
  input  wire logic                       cascadeServiceIn,
  input  wire logic                       cascadePendingIn,
  output logic                            cascadeServiceOut,
  output logic                            cascadePendingOut
);

  pic_pkg::pic_state_t state_ff;
  pic_pkg::pic_state_t nxt_state;

  logic [pic_pkg::NREQ-1:0]   reqActive;
  logic [pic_pkg::NREQ-1:0]   reqLatchQ;
  logic [pic_pkg::NREQ-1:0]   unmaskedPend;
  logic [pic_pkg::CODE_W-1:0] reqTopCode;
  logic                       reqAny;
  logic [pic_pkg::CODE_W-1:0] svcTopCode;
  logic                       svcAny;
  logic [pic_pkg::CODE_W-1:0] effSvcTop;
  logic                       effSvcAny;
  logic                       effCasSvc;
  logic                       instrOn;
  logic                       busOn;
  logic                       ackTaken;
  logic                       masterClear;
  logic                       clrTopSvc;
  logic                       clrCurPend;
  logic                       higherWaiting;
  logic [pic_pkg::NREQ-1:0]   ackHot;
  logic [pic_pkg::NREQ-1:0]   effTopHot;

  // request pins enter through the synchroniser and pulse latches
  pic_req_capture u_capture (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .requestLinesN (requestLinesN),
    .levelMode     (requestCaptureMode),
    .pendingQ      (state_ff.pendingRequestReg),
    .clearAll      (masterClear),
    .reqActive     (reqActive),
    .latchQ        (reqLatchQ)
  );

  // mask gates the stored requests before prioritising
  assign unmaskedPend = state_ff.pendingRequestReg
                      & ~state_ff.requestMaskReg; // R11 R12

  pic_prio_enc #(
    .WIDTH  (pic_pkg::NREQ),
    .CODE_W (pic_pkg::CODE_W)
  ) u_req_enc (
    .reqVec  (unmaskedPend),
    .topCode (reqTopCode),
    .anySet  (reqAny)
  ); // R11

  pic_prio_enc #(
    .WIDTH  (pic_pkg::NREQ),
    .CODE_W (pic_pkg::CODE_W)
  ) u_svc_enc (
    .reqVec  (state_ff.serviceTrackingReg),
    .topCode (svcTopCode),
    .anySet  (svcAny)
  );

  // delayed mode swaps in the copies taken one edge earlier
  always_comb begin
    if (delayedServiceMode) begin
      effCasSvc = state_ff.casSvcDly; // R20
      effSvcTop = state_ff.svcTopDly; // R20
      effSvcAny = state_ff.svcAnyDly; // R20
    end else begin
      effCasSvc = cascadeServiceIn;
      effSvcTop = svcTopCode;
      effSvcAny = svcAny;
    end
  end

  // instruction qualification
  assign instrOn = ~instrIn.instrValidN; // R6
  assign busOn   = instrOn & ~instrIn.chipSelectN
                 & (instrIn.opcodeIn >= pic_pkg::OP_BUS_FIRST); // R7

  // opcodes 0 to 3 do not look at chip select
  assign masterClear = instrOn
                     & (instrIn.opcodeIn == pic_pkg::OP_MASTER_CLEAR);
  assign clrTopSvc   = instrOn & ~effCasSvc
                     & (instrIn.opcodeIn == pic_pkg::OP_CLR_TOP_SVC); // R2
  assign clrCurPend  = instrOn & ~effCasSvc
                     & (instrIn.opcodeIn == pic_pkg::OP_CLR_CUR_PEND); // R2

  // acknowledge only counts while vector enable is set, which is
  // what lets chained devices share one acknowledge line
  assign ackTaken  = ~irqAcknowledgeN & state_ff.vectorEnable; // R18
  assign ackHot    = pic_pkg::pic_onehot(state_ff.vectorCodeReg);
  assign effTopHot = pic_pkg::pic_onehot(effSvcTop);

  // a waiting request must outrank the highest one in service
  assign higherWaiting = reqAny
                       & (~effSvcAny | (reqTopCode > effSvcTop)); // R14 R15

  // request pin: open collector, released during ack or cascade
  assign irqRequestNOut = 1'b0;
  assign irqRequestNOe  = higherWaiting & irqAcknowledgeN
                        & ~effCasSvc & ~cascadePendingIn; // R2 R3 R14

  // vector pins are enabled by ack only while vector enable is set
  assign vectorOut    = state_ff.vectorCodeReg; // R18
  assign vectorOe     = ackTaken; // R19
  assign vectorValidN = ~state_ff.vectorEnable; // R17

  // cascade outputs use the undelayed inputs
  assign cascadeServiceOut = svcAny | cascadeServiceIn; // R4
  assign cascadePendingOut = reqAny | cascadePendingIn; // R5

  // reads: bus is driven only for an enabled, selected read
  always_comb begin
    dataBusOut = pic_pkg::REG_RESET;
    dataBusOe  = 1'b0;
    if (busOn) begin
      if (instrIn.opcodeIn == pic_pkg::OP_READ_MASK) begin
        dataBusOut = state_ff.requestMaskReg;
        dataBusOe  = 1'b1; // R27
      end else if (instrIn.opcodeIn == pic_pkg::OP_READ_SVC) begin
        dataBusOut = state_ff.serviceTrackingReg;
        dataBusOe  = 1'b1; // R27
      end else if (instrIn.opcodeIn == pic_pkg::OP_READ_PEND) begin
        dataBusOut = state_ff.pendingRequestReg;
        dataBusOe  = 1'b1; // R27
      end
    end
  end

  // next state: hardware events first, instructions layered on top, then the ack pending clear, master clear last
  always_comb begin
    nxt_state = state_ff;

    // vector register follows the encoder on every edge
    nxt_state.vectorCodeReg = reqTopCode; // R13

    // vector enable: cleared by cascade, else tracks waiting requests
    if (cascadePendingIn) begin
      nxt_state.vectorEnable = 1'b0; // R3
    end else begin
      nxt_state.vectorEnable = reqAny; // R17
    end

    // one-edge copies for delayed mode
    nxt_state.casSvcDly = cascadeServiceIn; // R20
    nxt_state.svcTopDly = svcTopCode; // R20
    nxt_state.svcAnyDly = svcAny; // R20

    // pending: level mode follows the line, pulse mode the latch
    if (requestCaptureMode) begin
      nxt_state.pendingRequestReg = reqActive; // R9
    end else begin
      nxt_state.pendingRequestReg = state_ff.pendingRequestReg
                                  | reqLatchQ; // R8
    end

    // in-service: ack sets the bit of the vector being taken
    if (ackTaken) begin
      nxt_state.serviceTrackingReg = state_ff.serviceTrackingReg
                                   | ackHot; // R18 R16
    end

    // top clears act on the possibly delayed in-service priority
    if (clrTopSvc && effSvcAny) begin
      nxt_state.serviceTrackingReg = nxt_state.serviceTrackingReg
                                   & ~effTopHot; // R25
    end
    if (clrCurPend && effSvcAny) begin
      nxt_state.pendingRequestReg = nxt_state.pendingRequestReg
                                  & ~effTopHot; // R25
    end

    // bus instructions
    if (busOn) begin
      case (instrIn.opcodeIn)
        pic_pkg::OP_BSET_MASK: begin
          nxt_state.requestMaskReg = state_ff.requestMaskReg
                                   | dataBusIn; // R24
        end
        pic_pkg::OP_BCLR_MASK: begin
          nxt_state.requestMaskReg = state_ff.requestMaskReg
                                   & ~dataBusIn; // R24
        end
        pic_pkg::OP_LOAD_MASK: begin
          nxt_state.requestMaskReg = dataBusIn; // R23
        end
        // service writes come after ack so they win on their bits
        pic_pkg::OP_BSET_SVC: begin
          nxt_state.serviceTrackingReg = nxt_state.serviceTrackingReg
                                       | dataBusIn; // R24 R26
        end
        pic_pkg::OP_BCLR_SVC: begin
          nxt_state.serviceTrackingReg = nxt_state.serviceTrackingReg
                                       & ~dataBusIn; // R24 R26
        end
        pic_pkg::OP_LOAD_SVC: begin
          nxt_state.serviceTrackingReg = dataBusIn; // R26
        end
        pic_pkg::OP_BSET_PEND: begin
          nxt_state.pendingRequestReg = nxt_state.pendingRequestReg
                                      | dataBusIn; // R22 R24
        end
        pic_pkg::OP_BCLR_PEND: begin
          nxt_state.pendingRequestReg = nxt_state.pendingRequestReg
                                      & ~dataBusIn; // R24
        end
        pic_pkg::OP_LOAD_PEND: begin
          nxt_state.pendingRequestReg = dataBusIn; // R22
        end
        default: begin
          // reads leave all state alone
        end
      endcase
    end

    // ack clears its pending bit after the bus writes, so it beats pending writes
    if (ackTaken) begin
      nxt_state.pendingRequestReg = nxt_state.pendingRequestReg
                                  & ~ackHot; // R18 R26
    end

    // master clear empties the three registers like reset does
    if (masterClear) begin
      nxt_state.pendingRequestReg  = pic_pkg::REG_RESET; // R23
      nxt_state.requestMaskReg     = pic_pkg::REG_RESET;
      nxt_state.serviceTrackingReg = pic_pkg::REG_RESET;
    end
  end

  // single register stage for the whole core
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff.pendingRequestReg  <= pic_pkg::REG_RESET; // R21
      state_ff.requestMaskReg     <= pic_pkg::REG_RESET; // R21
      state_ff.serviceTrackingReg <= pic_pkg::REG_RESET; // R21
      state_ff.vectorCodeReg      <= pic_pkg::CODE_RESET;
      state_ff.vectorEnable       <= 1'b0;
      state_ff.casSvcDly          <= 1'b0;
      state_ff.svcTopDly          <= pic_pkg::CODE_RESET;
      state_ff.svcAnyDly          <= 1'b0;
    end else begin
      state_ff <= nxt_state; // R1
    end
  end

endmodule : pic_core

// File: pic_pkg.sv
package pic_pkg;

  // request count and width of the priority code
  localparam int NREQ   = 8;
  localparam int CODE_W = 3;

  // value that the pending, mask and in-service registers take on reset or master clear
  localparam logic [NREQ-1:0]   REG_RESET  = 8'h00;
  localparam logic [CODE_W-1:0] CODE_RESET = 3'h0;

  // instruction encoding on the opcode port
  typedef enum logic [3:0] {
    OP_MASTER_CLEAR = 4'b0000,
    OP_CLR_TOP_SVC  = 4'b0001,
    OP_CLR_CUR_PEND = 4'b0010,
    OP_NOP          = 4'b0011,
    OP_BSET_MASK    = 4'b0100,
    OP_BCLR_MASK    = 4'b0101,
    OP_LOAD_MASK    = 4'b0110,
    OP_READ_MASK    = 4'b0111,
    OP_BSET_SVC     = 4'b1000,
    OP_BCLR_SVC     = 4'b1001,
    OP_LOAD_SVC     = 4'b1010,
    OP_READ_SVC     = 4'b1011,
    OP_BSET_PEND    = 4'b1100,
    OP_BCLR_PEND    = 4'b1101,
    OP_LOAD_PEND    = 4'b1110,
    OP_READ_PEND    = 4'b1111
  } pic_op_t;

  // lowest opcode that uses the data bus and obeys chip select
  localparam logic [3:0] OP_BUS_FIRST = 4'h4;

  // instruction port: enable, chip select and opcode travel together
  typedef struct packed {
    logic    instrValidN;
    logic    chipSelectN;
    pic_op_t opcodeIn;
  } pic_instr_t;

  // request input synchroniser and pulse latches
  typedef struct packed {
    logic [NREQ-1:0] syncFirst;
    logic [NREQ-1:0] syncSecond;
    logic [NREQ-1:0] reqLatch;
  } pic_cap_t;

  // whole state of the controller core
  typedef struct packed {
    logic [NREQ-1:0]   pendingRequestReg;
    logic [NREQ-1:0]   requestMaskReg;
    logic [NREQ-1:0]   serviceTrackingReg;
    logic [CODE_W-1:0] vectorCodeReg;
    logic              vectorEnable;
    logic              casSvcDly;
    logic [CODE_W-1:0] svcTopDly;
    logic              svcAnyDly;
  } pic_state_t;

  // one-hot decode of a priority code
  function automatic logic [NREQ-1:0] pic_onehot(
    input logic [CODE_W-1:0] code
  );
    logic [NREQ-1:0] hot;
    hot       = REG_RESET;
    hot[code] = 1'b1;
    return hot;
  endfunction : pic_onehot

endpackage : pic_pkg

// File: pic_prio_enc.sv
`timescale 1ns/1ns
// highest-numbered set bit wins; any flags a non-empty vector
module pic_prio_enc #(
  parameter int WIDTH  = pic_pkg::NREQ,
  parameter int CODE_W = pic_pkg::CODE_W
) (
  input  wire logic [WIDTH-1:0]  reqVec,
  output logic      [CODE_W-1:0] topCode,
  output logic                   anySet
);

  // ascending scan so the last hit is the highest number
  always_comb begin
    topCode = '0;
    anySet  = 1'b0;
    for (int i = 0; i < WIDTH; i++) begin
      if (reqVec[i]) begin
        topCode = CODE_W'(i);
        anySet  = 1'b1;
      end
    end
  end

endmodule : pic_prio_enc

// File: pic_req_capture.sv
`timescale 1ns/1ns
// request pins: two-flop synchroniser, then pulse latches
module pic_req_capture (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic [pic_pkg::NREQ-1:0] requestLinesN,
  input  wire logic                     levelMode,
  input  wire logic [pic_pkg::NREQ-1:0] pendingQ,
  input  wire logic                     clearAll,
  output logic      [pic_pkg::NREQ-1:0] reqActive,
  output logic      [pic_pkg::NREQ-1:0] latchQ
);

  pic_pkg::pic_cap_t state_ff;
  pic_pkg::pic_cap_t nxt_state;

  // only the second flop is read; a pulse shorter than a clock
  // period can slip past the sampler, a cost of one clock domain
  assign reqActive = ~state_ff.syncSecond;
  assign latchQ    = state_ff.reqLatch;

  // set wins over the clear from the pending flop
  always_comb begin
    nxt_state            = state_ff;
    nxt_state.syncFirst  = requestLinesN;
    nxt_state.syncSecond = state_ff.syncFirst;
    if (levelMode || clearAll) begin
      nxt_state.reqLatch = pic_pkg::REG_RESET; // R9
    end else begin
      nxt_state.reqLatch = (state_ff.reqLatch & ~pendingQ)
                         | reqActive; // R8
    end
  end

  // sync flops idle high so no false request after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff.syncFirst  <= ~pic_pkg::REG_RESET;
      state_ff.syncSecond <= ~pic_pkg::REG_RESET;
      state_ff.reqLatch   <= pic_pkg::REG_RESET; // R21
    end else begin
      state_ff <= nxt_state; // R1
    end
  end

endmodule : pic_req_capture

// File: pic_core_sva.sv
`timescale 1ns/1ns
// watches the core pins only; gating and precedence slips trip these
module pic_core_sva (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire pic_pkg::pic_instr_t instrIn,
  input wire logic                dataBusOe,
  input wire logic                irqAcknowledgeN,
  input wire logic                irqRequestNOe,
  input wire logic                vectorOe,
  input wire logic                vectorValidN,
  input wire logic                delayedServiceMode,
  input wire logic                cascadeServiceIn,
  input wire logic                cascadePendingIn,
  input wire logic                cascadeServiceOut,
  input wire logic                cascadePendingOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // an acknowledge that the vector enable lets through
  sequence ackTaken;
    !irqAcknowledgeN && !vectorValidN;
  endsequence
  // no opcode that could touch the in-service bits this cycle
  sequence svcQuiet;
    instrIn.instrValidN || instrIn.opcodeIn[3:2] == 2'b01 ||
      instrIn.opcodeIn[3:2] == 2'b11 || instrIn.opcodeIn == pic_pkg::OP_NOP;
  endsequence

  // a selected, enabled read opcode is the only bus driver
  logic rdOp;
  assign rdOp = !instrIn.instrValidN && !instrIn.chipSelectN &&
                instrIn.opcodeIn[1:0] == 2'b11 &&
                instrIn.opcodeIn[3:2] != 2'b00;

  svc_out_a: assert property (cascadeServiceIn |-> cascadeServiceOut)
    else $error("service out low while service in high");
  pend_out_a: assert property (cascadePendingIn |-> cascadePendingOut)
    else $error("pending out low while pending in high");
  irq_src_a: assert property (irqRequestNOe |->
      cascadePendingOut && irqAcknowledgeN && !cascadePendingIn)
    else $error("request raised without a cause");
  irq_casc_a: assert property (
      !delayedServiceMode && cascadeServiceIn |-> !irqRequestNOe)
    else $error("request raised under service in");
  vec_oe_a: assert property (
      vectorOe == (!irqAcknowledgeN && !vectorValidN))
    else $error("vector pins enable wrong");
  ven_clear_a: assert property (cascadePendingIn |=> vectorValidN)
    else $error("vector enable kept under pending in");
  ven_follow_a: assert property (
      !cascadePendingIn |=> vectorValidN == !$past(cascadePendingOut))
    else $error("vector enable does not follow pending");
  bus_drive_a: assert property (dataBusOe == rdOp)
    else $error("data bus drive wrong");
  ack_take_a: assert property (ackTaken ##0 svcQuiet |=> cascadeServiceOut)
    else $error("acknowledge set no service bit");
  svc_hold_a: assert property (
      cascadeServiceOut && !cascadeServiceIn ##0 svcQuiet |=> cascadeServiceOut)
    else $error("service bit lost without instruction");
  reset_clear_a: assert property (disable iff (1'b0) !rst_n |=>
      vectorValidN && cascadeServiceOut == cascadeServiceIn)
    else $error("state not cleared by reset");
endmodule : pic_core_sva

bind pic_core pic_core_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .instrIn(instrIn), .dataBusOe(dataBusOe), .irqAcknowledgeN(irqAcknowledgeN),
  .irqRequestNOe(irqRequestNOe), .vectorOe(vectorOe),
  .vectorValidN(vectorValidN), .delayedServiceMode(delayedServiceMode),
  .cascadeServiceIn(cascadeServiceIn), .cascadePendingIn(cascadePendingIn),
  .cascadeServiceOut(cascadeServiceOut),
  .cascadePendingOut(cascadePendingOut));

// File: pic_seq_model.sv
`timescale 1ns/1ns
// sequencer stand-in: reads the shared request wire at the edge and
// answers with a one-cycle acknowledge after ackDly waiting cycles
module pic_seq_model (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       irqWireN,
  input wire logic       ackOn,
  input wire logic [3:0] ackDly,
  output logic           irqAcknowledgeN
);
  logic [3:0] waitCnt;

  initial begin
    irqAcknowledgeN = 1'b1;
    waitCnt = 4'h0;
  end

  // a dropped request restarts the wait, as a real sequencer would
  always @(posedge clk_sys) begin
    logic seen;
    seen = !irqWireN && rst_n && ackOn;
    #1;
    if (!irqAcknowledgeN || !seen) begin
      irqAcknowledgeN = 1'b1;
      waitCnt = 4'h0;
    end else if (waitCnt == ackDly) begin
      irqAcknowledgeN = 1'b0;
    end else begin
      waitCnt = waitCnt + 4'h1;
    end
  end
endmodule : pic_seq_model

// File: priority_interrupt_controller_tb_top.sv
`timescale 1ns/1ns
module priority_interrupt_controller_tb_top;
  logic                clk_sys;
  logic                rst_n;
  logic [7:0]          requestLinesN;
  logic                requestCaptureMode;
  logic                delayedServiceMode;
  pic_pkg::pic_instr_t instrIn;
  logic [7:0]          dataBusIn;
  logic [7:0]          dataBusOut;
  logic                dataBusOe;
  logic                irqAcknowledgeN;
  logic                irqRequestNOut;
  logic                irqRequestNOe;
  logic [2:0]          vectorOut;
  logic                vectorOe;
  logic                vectorValidN;
  logic                cascadeServiceIn;
  logic                cascadePendingIn;
  logic                cascadeServiceOut;
  logic                cascadePendingOut;
  logic                ackOn;
  logic [3:0]          ackDly;
  wire                 irqWireN;
  wire  [2:0]          vecPins;
  int                  err_count;
  int                  comparisons;
  int                  cycles;
  logic [7:0]          rdQ[$];
  logic [2:0]          vecQ[$];

  // open-collector request line with pull-up; vector pins float when idle
  assign irqWireN = irqRequestNOe ? irqRequestNOut : 1'b1;
  assign vecPins  = vectorOe ? vectorOut : 3'hz;

  pic_core dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .requestLinesN(requestLinesN), .requestCaptureMode(requestCaptureMode),
    .delayedServiceMode(delayedServiceMode), .instrIn(instrIn),
    .dataBusIn(dataBusIn), .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
    .irqAcknowledgeN(irqAcknowledgeN), .irqRequestNOut(irqRequestNOut),
    .irqRequestNOe(irqRequestNOe), .vectorOut(vectorOut),
    .vectorOe(vectorOe), .vectorValidN(vectorValidN),
    .cascadeServiceIn(cascadeServiceIn), .cascadePendingIn(cascadePendingIn),
    .cascadeServiceOut(cascadeServiceOut),
    .cascadePendingOut(cascadePendingOut));

  pic_seq_model seq (.clk_sys(clk_sys), .rst_n(rst_n), .irqWireN(irqWireN),
    .ackOn(ackOn), .ackDly(ackDly), .irqAcknowledgeN(irqAcknowledgeN));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // results on the pins are paired with the oldest note; a hang is cut off
  always @(posedge clk_sys) begin
    cycles++;
    if (vectorOe === 1'b1)
      chk(8'(vecPins), vecQ.size() ? 8'(vecQ.pop_front()) : 8'hxx);
    if (dataBusOe === 1'b1)
      chk(dataBusOut, rdQ.size() ? rdQ.pop_front() : 8'hxx);
    if (cycles == 5000) begin
      err_count++;
      $display("Error at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  // one instruction stands for one edge, then the enable drops
  task automatic op(input logic [3:0] o, input logic [7:0] d,
                    input logic csN = 1'b0);
    cyc(1);
    instrIn = {1'b0, csN, o};
    dataBusIn = d;
    cyc(1);
    instrIn.instrValidN = 1'b1;
  endtask : op

  task automatic rd(input logic [3:0] o, input logic [7:0] e);
    rdQ.push_back(e);
    op(o, 8'h00);
  endtask : rd

  task automatic pulse(input int ch);
    cyc(1);
    requestLinesN[ch] = 1'b0;
    cyc(2);
    requestLinesN[ch] = 1'b1;
  endtask : pulse

  // bounded wait until every noted vector has been taken
  task automatic waitVec();
    for (int i = 0; i < 60 && vecQ.size() > 0; i++) @(posedge clk_sys);
    #1;
    chk(8'(vecQ.size()), 8'h00);
    vecQ.delete();
  endtask : waitVec

  initial begin
    logic [7:0] d, e;
    int k, j, m;
    {rst_n, requestCaptureMode, delayedServiceMode, ackOn} = 4'h0;
    {cascadeServiceIn, cascadePendingIn, err_count, comparisons} = '0;
    {requestLinesN, instrIn, dataBusIn, ackDly, cycles} = {8'hff, 6'h23, 44'h0};
    void'($urandom(59236));
    k = $urandom_range(5, 2);
    j = $urandom_range(7, k + 1);
    m = $urandom_range(k - 1, 0);
    cyc(4);
    rst_n = 1'b1;
    chk({7'h00, vectorValidN}, 8'h01);
    for (int g = 7; g < 16; g += 4) rd(4'(g), 8'h00);
    // each register group: load, bit set, bit clear, read back
    for (int g = 4; g < 16; g += 4) begin
      d = 8'($urandom);
      e = 8'($urandom);
      op(4'(g + 2), d);
      op(4'(g), e);
      d = d | e;
      e = 8'($urandom);
      op(4'(g + 1), e);
      rd(4'(g + 3), d & ~e);
    end
    d = d & ~e;
    op(4'he, ~d, 1'b1);
    rd(4'hf, d);
    cyc(1);
    instrIn = {2'b10, 4'h0};
    rd(4'hf, d);
    op(4'ha, 8'(1 << k));
    op(4'hc, 8'hff);
    op(4'h2, 8'h00);
    rd(4'hf, ~8'(1 << k));
    op(4'h0, 8'h00);
    for (int g = 7; g < 16; g += 4) rd(4'(g), 8'h00);
    // nested service: higher preempts, lower waits for both clears
    ackOn = 1'b1;
    vecQ.push_back(3'(k));
    pulse(k);
    waitVec();
    vecQ.push_back(3'(j));
    pulse(j);
    waitVec();
    pulse(m);
    cyc(6);
    chk({7'h00, irqWireN}, 8'h01);
    rd(4'hb, 8'((1 << j) | (1 << k)));
    chk({7'h00, cascadeServiceOut}, 8'h01);
    op(4'h1, 8'h00);
    cyc(6);
    chk({7'h00, irqWireN}, 8'h01);
    vecQ.push_back(3'(m));
    op(4'h1, 8'h00);
    waitVec();
    op(4'h1, 8'h00);
    // masked request is kept but silent; cascade holds it off, slow ack
    ackDly = 4'h3;
    op(4'h6, 8'(1 << k));
    pulse(k);
    cyc(6);
    rd(4'hf, 8'(1 << k));
    cascadePendingIn = 1'b1;
    op(4'h6, 8'h00);
    cyc(4);
    chk({6'h00, irqWireN, vectorValidN}, 8'h03);
    vecQ.push_back(3'(k));
    cascadePendingIn = 1'b0;
    waitVec();
    cascadeServiceIn = 1'b1;
    op(4'h1, 8'h00);
    cascadeServiceIn = 1'b0;
    rd(4'hb, 8'(1 << k));
    op(4'h1, 8'h00);
    // level mode: the source holds its line until it is taken
    requestCaptureMode = 1'b1;
    delayedServiceMode = 1'b1;
    ackDly = 4'h0;
    vecQ.push_back(3'(j));
    requestLinesN[j] = 1'b0;
    waitVec();
    requestLinesN[j] = 1'b1;
    cyc(5);
    rd(4'hf, 8'h00);
    op(4'h1, 8'h00);
    rd(4'hb, 8'h00);
    chk({6'h00, cascadeServiceOut, cascadePendingOut}, 8'h00);
    cyc(2);
    tally_and_finish();
  end
endmodule : priority_interrupt_controller_tb_top
